// File: uoi_intc.sv
/*
  USB OTG interrupt flag and enable block with APB register access.
  Line, supply and serial-engine events set write-one-to-clear flags.
  Assumes all inputs synchronous to pclk; serial-engine events are pulses.
*/
// Overview of operation
// - Flags stay set until one written there
// - Host mode: ID pin change sets flag
// - One-millisecond timer expiry sets its flag
// - Line state stable 1 ms, changed, sets
// - Any data-line or supply activity sets flag
// - Supply threshold crossings either direction set flags
// - OTG enables align with flags, bit1 absent
// - STALL handshake sent sets stall flag
// - K-state held 2.5 us sets resume
// - Idle state 3 ms sets idle
// - Token done sets; clearing advances status FIFO
// - Frame start: token received or threshold reached
// - Only enabled errors set error summary
// - Device reset 2.5 us sets, once per reset
// - Host attach: no SE0, quiet 2.5 us
// - Host detach sets, once per reset state
// - Main flag layout depends on host mode
// - Unimplemented bits read zero; all reset zero
// - J-state polarity follows bus speed
// - Host frame threshold is the sof_thr register value
`timescale 1ns/1ns
module uoi_intc #(
  parameter logic [uoi_pkg::CNT_W-1:0] MS_CYC = uoi_pkg::MS_CYC_DEF,
  parameter logic [uoi_pkg::CNT_W-1:0] STABLE_CYC = uoi_pkg::STABLE_CYC_DEF,
  parameter logic [uoi_pkg::CNT_W-1:0] IDLE_CYC = uoi_pkg::IDLE_CYC_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic host_mode,
  input wire uoi_pkg::uoi_line_t line_in,
  input wire uoi_pkg::uoi_sie_t sie_in,
  output logic usb_irq,
  output logic stat_advance
);
  import uoi_pkg::*;

  typedef struct packed {
    logic [7:0] otg_flags;
    logic [7:0] otg_en;
    logic [7:0] usb_flags;
    logic [7:0] usb_en;
    logic [7:0] err_en;
    logic [7:0] sof_thr;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic irq;
    logic stat_adv;
    logic id_prev;
    logic [2:0] vbus_prev;
    logic [1:0] line_prev;
    logic [1:0] line_stable;
    logic diff_prev;
    logic [7:0] frame_prev;
    logic [CNT_W-1:0] ms_cnt;
  } uoi_state_t;

  uoi_state_t s_q;
  uoi_state_t s_d;

  // W1C update: clear flags where the bus writes a one, then OR in new sets
  function automatic logic [7:0] w1c(input logic [7:0] flags, input logic [7:0] set,
                                     input logic wr, input logic [7:0] wd);
    w1c = (flags & ~(wr ? wd : 8'h00)) | set;
  endfunction

  function automatic logic map_hit(input logic [7:0] a);
    map_hit = (a == OFS_OTG_FLAGS) || (a == OFS_OTG_EN) || (a == OFS_USB_FLAGS) ||
              (a == OFS_USB_EN) || (a == OFS_ERR_EN) || (a == OFS_SOF_THR);
  endfunction

  logic j_now;
  logic k_now;
  logic [1:0] line_now;
  logic act_now;
  logic [7:0] usb_mask;
  logic [2:0] vbus_now;
  logic stable_fire;
  logic resume_fire;
  logic idle_fire;
  logic attach_fire;
  logic se0_fire;
  logic acc_done;
  logic [7:0] otg_set;
  logic [7:0] usb_set;

  // Line decode; J and K swap with speed
  always_comb
  begin
    j_now = !line_in.se0 && (line_in.low_speed ? !line_in.diff : line_in.diff);
    k_now = !line_in.se0 && (line_in.low_speed ? line_in.diff : !line_in.diff);
    line_now = {line_in.se0, j_now};
    vbus_now = {line_in.sess_valid, line_in.b_sess_end, line_in.a_vbus_valid};
    act_now = (line_in.diff != s_q.diff_prev) || (line_in.se0 != s_q.line_prev[1]) ||
              (vbus_now != s_q.vbus_prev);
    usb_mask = host_mode ? USB_MASK_HOST : USB_MASK_DEV;
    acc_done = psel && penable && s_q.ready;
  end

  // Hold timers for the timed line conditions
  uoi_hold_timer #(.LIMIT(STABLE_CYC)) u_stable (
    .pclk(pclk), .presetn(presetn), .cond(line_now == s_q.line_prev), .fire(stable_fire));
  uoi_hold_timer #(.LIMIT(K_CYC)) u_resume (
    .pclk(pclk), .presetn(presetn), .cond(k_now), .fire(resume_fire));
  uoi_hold_timer #(.LIMIT(IDLE_CYC)) u_idle (
    .pclk(pclk), .presetn(presetn), .cond(j_now), .fire(idle_fire));
  uoi_hold_timer #(.LIMIT(ATTACH_CYC)) u_attach (
    .pclk(pclk), .presetn(presetn), .cond(!line_in.se0 && !act_now), .fire(attach_fire));
  uoi_hold_timer #(.LIMIT(RESET_CYC)) u_se0 (
    .pclk(pclk), .presetn(presetn), .cond(line_in.se0), .fire(se0_fire));

  // Event sources for both flag groups
  always_comb
  begin
    otg_set = 8'h00;
    otg_set[B_ID_CHANGE] = host_mode && (line_in.id_pin != s_q.id_prev);
    otg_set[B_MS_TIMER] = s_q.ms_cnt == MS_CYC - CNT_W'(1);
    otg_set[B_LINE_STABLE] = stable_fire && (line_now != s_q.line_stable);
    otg_set[B_BUS_ACTIVITY] = act_now;
    otg_set[B_SESS_VALID] = vbus_now[2] != s_q.vbus_prev[2];
    otg_set[B_B_SESS_END] = vbus_now[1] != s_q.vbus_prev[1];
    otg_set[B_A_VBUS_VALID] = vbus_now[0] != s_q.vbus_prev[0];
    usb_set = 8'h00;
    usb_set[B_STALL] = sie_in.stall_sent;
    usb_set[B_ATTACH] = host_mode && attach_fire;
    usb_set[B_RESUME] = resume_fire;
    usb_set[B_IDLE] = idle_fire;
    usb_set[B_TOKEN_DONE] = sie_in.token_done;
    usb_set[B_FRAME_START] = host_mode ?
      (sie_in.frame_cnt == s_q.sof_thr) && (s_q.frame_prev != s_q.sof_thr) : sie_in.sof_rx;
    usb_set[B_ERROR] = |(sie_in.err & s_q.err_en);
    usb_set[B_RESET_DETACH] = se0_fire;
  end

  // Next state: bus access, flags, history and interrupt
  always_comb
  begin
    s_d = s_q;
    s_d.stat_adv = 1'b0;
    // Access phase: answer after one wait state
    s_d.ready = psel && penable && !s_q.ready;
    s_d.slverr = 1'b0;
    if (psel && penable && !s_q.ready)
    begin
      s_d.slverr = !map_hit(paddr);
      case (paddr)
        OFS_OTG_FLAGS: s_d.rdata = {24'h000000, s_q.otg_flags & OTG_MASK};
        OFS_OTG_EN: s_d.rdata = {24'h000000, s_q.otg_en & OTG_MASK};
        OFS_USB_FLAGS: s_d.rdata = {24'h000000, s_q.usb_flags & usb_mask};
        OFS_USB_EN: s_d.rdata = {24'h000000, s_q.usb_en & usb_mask};
        OFS_ERR_EN: s_d.rdata = {24'h000000, s_q.err_en};
        OFS_SOF_THR: s_d.rdata = {24'h000000, s_q.sof_thr};
        default: s_d.rdata = 32'h00000000;
      endcase
    end
    // Flags: set wins over a same-cycle clear
    s_d.otg_flags = w1c(s_q.otg_flags, otg_set,
      acc_done && pwrite && paddr == OFS_OTG_FLAGS, pwdata[7:0]) & OTG_MASK;
    s_d.usb_flags = w1c(s_q.usb_flags, usb_set,
      acc_done && pwrite && paddr == OFS_USB_FLAGS, pwdata[7:0] & usb_mask);
    // Clearing token done pops the transfer status FIFO
    s_d.stat_adv = acc_done && pwrite && paddr == OFS_USB_FLAGS &&
                   pwdata[B_TOKEN_DONE] && s_q.usb_flags[B_TOKEN_DONE];
    if (acc_done && pwrite)
    begin
      case (paddr)
        OFS_OTG_EN: s_d.otg_en = pwdata[7:0] & OTG_MASK;
        OFS_USB_EN: s_d.usb_en = pwdata[7:0];
        OFS_ERR_EN: s_d.err_en = pwdata[7:0];
        OFS_SOF_THR: s_d.sof_thr = pwdata[7:0];
        default: s_d.sof_thr = s_q.sof_thr;
      endcase
    end
    // Free-running millisecond timer
    s_d.ms_cnt = (s_q.ms_cnt == MS_CYC - CNT_W'(1)) ? '0 : s_q.ms_cnt + CNT_W'(1);
    if (stable_fire)
    begin
      s_d.line_stable = line_now;
    end
    s_d.id_prev = line_in.id_pin;
    s_d.vbus_prev = vbus_now;
    s_d.line_prev = line_now;
    s_d.diff_prev = line_in.diff;
    s_d.frame_prev = sie_in.frame_cnt;
    // Interrupt request from any enabled flag
    s_d.irq = |(s_q.otg_flags & s_q.otg_en & OTG_MASK) |
              |(s_q.usb_flags & s_q.usb_en & usb_mask);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign prdata = s_q.rdata;
  assign pready = s_q.ready;
  assign pslverr = s_q.slverr;
  assign usb_irq = s_q.irq;
  assign stat_advance = s_q.stat_adv;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ID flag held with no write to its register
  sequence seq_id_held;
    s_q.otg_flags[B_ID_CHANGE] && !(acc_done && pwrite && paddr == OFS_OTG_FLAGS);
  endsequence

  // Session-valid level differs from the last sample
  sequence seq_sess_cross;
    line_in.sess_valid != s_q.vbus_prev[2];
  endsequence

  // Reset timer fired and SE0 still held
  sequence seq_se0_fired;
    se0_fire ##1 line_in.se0;
  endsequence

  // Access phase still waiting for its answer
  sequence seq_apb_wait;
    psel && penable && !pready;
  endsequence

  // Sticky flags, cleared only by a written one
  flag_hold_a: assert property (seq_id_held
    |=> s_q.otg_flags[B_ID_CHANGE])
    else $error("flag dropped without a clear");
  w1c_clear_a: assert property (acc_done && pwrite && paddr == OFS_USB_FLAGS && pwdata[B_STALL]
    && !sie_in.stall_sent |=> !s_q.usb_flags[B_STALL])
    else $error("written one left the flag set");

  // ID change and millisecond timer
  id_change_a: assert property (host_mode && line_in.id_pin != s_q.id_prev
    |=> s_q.otg_flags[B_ID_CHANGE])
    else $error("id change not flagged");
  id_device_a: assert property (!host_mode && !s_q.otg_flags[B_ID_CHANGE]
    |=> !s_q.otg_flags[B_ID_CHANGE])
    else $error("id change flagged in device mode");
  ms_timer_a: assert property (s_q.ms_cnt == MS_CYC - CNT_W'(1)
    |=> s_q.otg_flags[B_MS_TIMER] && s_q.ms_cnt == '0)
    else $error("ms timer expiry missed");

  // Line stability and bus activity
  stable_set_a: assert property (stable_fire && line_now != s_q.line_stable
    |=> s_q.otg_flags[B_LINE_STABLE])
    else $error("stable line state not flagged");
  act_flag_a: assert property (act_now
    |=> s_q.otg_flags[B_BUS_ACTIVITY])
    else $error("bus activity not flagged");
  j_speed_a: assert property (!line_in.se0 && line_in.low_speed && !line_in.diff
    |-> j_now && !k_now)
    else $error("low speed J state misread");

  // Supply threshold crossings
  sess_cross_a: assert property (seq_sess_cross
    |=> s_q.otg_flags[B_SESS_VALID])
    else $error("supply crossing missed");
  vbus_cross_a: assert property (line_in.a_vbus_valid != s_q.vbus_prev[0]
    |=> s_q.otg_flags[B_A_VBUS_VALID])
    else $error("vbus valid crossing missed");

  // OTG enables keep only implemented bits
  en_mask_a: assert property (acc_done && pwrite && paddr == OFS_OTG_EN
    |=> s_q.otg_en == ($past(pwdata[7:0]) & OTG_MASK))
    else $error("otg enable write wrong");

  // Transaction flags
  stall_seen_a: assert property (sie_in.stall_sent
    |=> s_q.usb_flags[B_STALL])
    else $error("stall not flagged");
  token_seen_a: assert property (sie_in.token_done
    |=> s_q.usb_flags[B_TOKEN_DONE])
    else $error("token done not flagged");
  stat_pop_a: assert property (stat_advance
    |-> $past(s_q.usb_flags[B_TOKEN_DONE]))
    else $error("fifo advanced without token flag");

  // Frame start in either mode
  sof_dev_a: assert property (!host_mode && sie_in.sof_rx
    |=> s_q.usb_flags[B_FRAME_START])
    else $error("received frame start not flagged");
  sof_host_a: assert property (host_mode && sie_in.frame_cnt == s_q.sof_thr
    && s_q.frame_prev != s_q.sof_thr |=> s_q.usb_flags[B_FRAME_START])
    else $error("host frame threshold not flagged");

  // Error summary gated by the error enables
  err_set_a: assert property (|(sie_in.err & s_q.err_en)
    |=> s_q.usb_flags[B_ERROR])
    else $error("enabled error not flagged");
  err_masked_a: assert property ((sie_in.err & s_q.err_en) == 8'h00 && !s_q.usb_flags[B_ERROR]
    |=> !s_q.usb_flags[B_ERROR])
    else $error("masked error set summary");

  // Timed line conditions
  resume_seen_a: assert property (resume_fire
    |=> s_q.usb_flags[B_RESUME])
    else $error("resume not flagged");
  idle_seen_a: assert property (idle_fire
    |=> s_q.usb_flags[B_IDLE])
    else $error("idle not flagged");
  attach_seen_a: assert property (host_mode && attach_fire
    |=> s_q.usb_flags[B_ATTACH])
    else $error("attach not flagged");
  attach_dev_a: assert property (!host_mode && !s_q.usb_flags[B_ATTACH]
    |=> !s_q.usb_flags[B_ATTACH])
    else $error("attach flagged in device mode");

  // Reset or detach, once per SE0 period
  reset_seen_a: assert property (se0_fire
    |=> s_q.usb_flags[B_RESET_DETACH])
    else $error("reset or detach not flagged");
  once_per_se0_a: assert property (seq_se0_fired
    |-> !se0_fire)
    else $error("reset or detach raised twice in one period");

  // Read-back and interrupt request
  upper_zero_a: assert property (pready
    |-> prdata[31:8] == 24'h000000 && !s_q.otg_flags[1])
    else $error("unimplemented bits set");
  irq_follow_a: assert property (|(s_q.otg_flags & s_q.otg_en)
    |=> usb_irq)
    else $error("enabled flag gave no interrupt");
  irq_usb_a: assert property (|(s_q.usb_flags & s_q.usb_en & usb_mask)
    |=> usb_irq)
    else $error("enabled main flag gave no interrupt");
  irq_quiet_a: assert property ((s_q.otg_flags & s_q.otg_en & OTG_MASK) == 8'h00
    && (s_q.usb_flags & s_q.usb_en & usb_mask) == 8'h00 |=> !usb_irq)
    else $error("interrupt without an enabled flag");

  // Bus answer timing
  apb_wait_a: assert property (seq_apb_wait
    |=> pready ##1 !pready)
    else $error("apb answer timing wrong");
  slverr_pair_a: assert property (pslverr
    |-> pready)
    else $error("slave error outside the answer cycle");
endmodule // uoi_intc

// File: uoi_pkg.sv
/*
  Package for the USB OTG interrupt flag block: register offsets, bit
  positions, masks, reset values, timing constants and carrier structs.
  Assumes a 100 MHz APB clock.
*/
package uoi_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_OTG_FLAGS = 8'h00;
  localparam logic [7:0] OFS_OTG_EN = 8'h04;
  localparam logic [7:0] OFS_USB_FLAGS = 8'h08;
  localparam logic [7:0] OFS_USB_EN = 8'h0c;
  localparam logic [7:0] OFS_ERR_EN = 8'h10;
  localparam logic [7:0] OFS_SOF_THR = 8'h14;
  // Field positions, OTG group
  localparam int B_ID_CHANGE = 7;
  localparam int B_MS_TIMER = 6;
  localparam int B_LINE_STABLE = 5;
  localparam int B_BUS_ACTIVITY = 4;
  localparam int B_SESS_VALID = 3;
  localparam int B_B_SESS_END = 2;
  localparam int B_A_VBUS_VALID = 0;
  // Field positions, main group
  localparam int B_STALL = 7;
  localparam int B_ATTACH = 6;
  localparam int B_RESUME = 5;
  localparam int B_IDLE = 4;
  localparam int B_TOKEN_DONE = 3;
  localparam int B_FRAME_START = 2;
  localparam int B_ERROR = 1;
  localparam int B_RESET_DETACH = 0;
  // Implemented-bit masks and reset value
  localparam logic [7:0] OTG_MASK = 8'hfd;
  localparam logic [7:0] USB_MASK_HOST = 8'hff;
  localparam logic [7:0] USB_MASK_DEV = 8'hbf;
  localparam logic [7:0] FLAG_RESET = 8'h00;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_TIMER_NS = 1000000;
  localparam int LINE_STABLE_NS = 1000000;
  localparam int IDLE_NS = 3000000;
  localparam int K_HOLD_NS = 2500;
  localparam int ATTACH_NS = 2500;
  localparam int RESET_NS = 2500;
  localparam int CNT_W = 19;
  localparam logic [CNT_W-1:0] MS_CYC_DEF = CNT_W'(MS_TIMER_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] STABLE_CYC_DEF = CNT_W'((LINE_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] IDLE_CYC_DEF = CNT_W'((IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] K_CYC = CNT_W'((K_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] ATTACH_CYC = CNT_W'((ATTACH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RESET_CYC = CNT_W'((RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Sampled bus line and supply levels
  typedef struct packed {
    logic diff;
    logic se0;
    logic low_speed;
    logic id_pin;
    logic sess_valid;
    logic b_sess_end;
    logic a_vbus_valid;
  } uoi_line_t;

  // Transaction events from the serial engine
  typedef struct packed {
    logic stall_sent;
    logic token_done;
    logic sof_rx;
    logic [7:0] err;
    logic [7:0] frame_cnt;
  } uoi_sie_t;
endpackage

// File: uoi_hold_timer.sv
/*
  Hold timer: pulses once when a condition has held for LIMIT cycles.
  Assumes cond is synchronous to pclk.
*/
`timescale 1ns/1ns
module uoi_hold_timer #(
  parameter logic [uoi_pkg::CNT_W-1:0] LIMIT = uoi_pkg::K_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cond,
  output logic fire
);
  import uoi_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic fire;
  } uoi_ht_state_t;

  uoi_ht_state_t s_q;
  uoi_ht_state_t s_d;

  // Count while held, saturate at LIMIT, restart when the condition drops
  always_comb
  begin
    s_d = s_q;
    s_d.fire = 1'b0;
    if (!cond)
    begin
      s_d.cnt = '0;
    end
    else if (s_q.cnt != LIMIT)
    begin
      s_d.cnt = s_q.cnt + CNT_W'(1);
      s_d.fire = (s_q.cnt + CNT_W'(1)) == LIMIT;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign fire = s_q.fire;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  fire_once_a: assert property (fire |=> !fire) else $error("hold timer fired twice in a row");
endmodule // uoi_hold_timer

// File: uoi_bus_model.sv
/*
  Bus-side model: drives line and supply levels and serial-engine pulses.
  Assumes its tasks are called right after a rising edge of pclk.
*/
`timescale 1ns/1ns
module uoi_bus_model (
  input wire logic pclk,
  output uoi_pkg::uoi_line_t line,
  output uoi_pkg::uoi_sie_t sie
);
  import uoi_pkg::*;
  // Quiet bus at start
  initial
  begin
    line = '0;
    sie = '0;
  end
  // New line levels
  task automatic set_line(input uoi_line_t v);
    line <= v;
  endtask
  // Host frame counter level
  task automatic set_frame(input logic [7:0] f);
    sie.frame_cnt <= f;
  endtask
  // One-cycle pulses: stall, token, sof, err[7:0]
  task automatic pulse(input logic [10:0] p);
    {sie.stall_sent, sie.token_done, sie.sof_rx, sie.err} <= p;
    @(posedge pclk);
    {sie.stall_sent, sie.token_done, sie.sof_rx, sie.err} <= 11'h000;
  endtask
endmodule // uoi_bus_model

// File: tb.sv
/*
  Self-checking bench for the USB OTG interrupt flag block.
  Assumes short timer parameters and one idle cycle between APB transfers.
*/
`timescale 1ns/1ns
module tb;
  import uoi_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, host_mode, pready, pslverr, usb_irq, stat_advance, err_seen;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  uoi_line_t line_w, lv;
  uoi_sie_t sie_w;
  int bad_count = 0;
  int n_compared = 0;
  int adv_count = 0;
  // Clock
  initial pclk = 1'b0;
  always #5 pclk = ~pclk;
  uoi_intc #(.MS_CYC(19'h14), .STABLE_CYC(19'h14), .IDLE_CYC(19'h28)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .host_mode(host_mode), .line_in(line_w), .sie_in(sie_w), .usb_irq(usb_irq),
    .stat_advance(stat_advance));
  uoi_bus_model u_bus (.pclk(pclk), .line(line_w), .sie(sie_w));
  // Count status-advance pulses
  always @(posedge pclk)
    if (stat_advance === 1'b1)
      adv_count <= adv_count + 1;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // APB transfer, ends at the completing edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    chk("pready", {31'd0, pready}, 32'd1);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rd & m, e);
  endtask
  task automatic t_reset();
    rchk("usb_flags", OFS_USB_FLAGS, 32'hffffff8e, 32'h0);
    rchk("otg_en", OFS_OTG_EN, 32'hffffffff, 32'h0);
    rchk("usb_en", OFS_USB_EN, 32'hffffffff, 32'h0);
    apb(1'b1, OFS_OTG_EN, 32'hffffffff);
    rchk("otg_en_bits", OFS_OTG_EN, 32'hffffffff, 32'h000000fd);
    apb(1'b1, OFS_OTG_EN, 32'h0);
    apb(1'b0, 8'he0, 32'h0);
    chk("slverr", {31'd0, err_seen}, 32'd1);
  endtask
  task automatic t_token();
    int k;
    apb(1'b1, OFS_USB_EN, 32'h08);
    u_bus.pulse(11'h200);
    cyc(2);
    rchk("token_set", OFS_USB_FLAGS, 32'h08, 32'h08);
    chk("irq_on", {31'd0, usb_irq}, 32'd1);
    apb(1'b1, OFS_USB_FLAGS, 32'hfffffff7);
    rchk("token_kept", OFS_USB_FLAGS, 32'h08, 32'h08);
    k = adv_count;
    apb(1'b1, OFS_USB_FLAGS, 32'h08);
    cyc(2);
    rchk("token_clr", OFS_USB_FLAGS, 32'h08, 32'h0);
    chk("advance", 32'(adv_count - k), 32'd1);
    chk("irq_off", {31'd0, usb_irq}, 32'd0);
    apb(1'b1, OFS_USB_EN, 32'h0);
  endtask
  task automatic t_error();
    apb(1'b1, OFS_ERR_EN, 32'h01);
    apb(1'b1, OFS_USB_FLAGS, 32'h06);
    u_bus.pulse(11'h0fe);
    cyc(2);
    rchk("err_masked", OFS_USB_FLAGS, 32'h06, 32'h0);
    u_bus.pulse(11'h101);
    cyc(2);
    rchk("err_sof", OFS_USB_FLAGS, 32'h06, 32'h06);
  endtask
  task automatic t_supply();
    apb(1'b1, OFS_OTG_FLAGS, 32'hff);
    lv[2:0] = 3'b111;
    u_bus.set_line(lv);
    cyc(2);
    rchk("vbus_rise", OFS_OTG_FLAGS, 32'h1d, 32'h1d);
    apb(1'b1, OFS_OTG_FLAGS, 32'h0d);
    lv[2:0] = 3'b000;
    u_bus.set_line(lv);
    cyc(2);
    rchk("vbus_fall", OFS_OTG_FLAGS, 32'h0d, 32'h0d);
    apb(1'b1, OFS_OTG_FLAGS, 32'h60);
    lv.diff = 1'b1;
    u_bus.set_line(lv);
    cyc(30);
    rchk("stable_ms", OFS_OTG_FLAGS, 32'h60, 32'h60);
    rchk("idle_early", OFS_USB_FLAGS, 32'h10, 32'h0);
    cyc(5);
    rchk("idle_set", OFS_USB_FLAGS, 32'h10, 32'h10);
  endtask
  task automatic t_bus_reset();
    apb(1'b1, OFS_USB_FLAGS, 32'hff);
    lv.se0 = 1'b1;
    u_bus.set_line(lv);
    cyc(230);
    rchk("reset_early", OFS_USB_FLAGS, 32'h01, 32'h0);
    cyc(25);
    rchk("reset_set", OFS_USB_FLAGS, 32'h01, 32'h01);
    apb(1'b1, OFS_USB_FLAGS, 32'h01);
    cyc(260);
    rchk("reset_once", OFS_USB_FLAGS, 32'h01, 32'h0);
    lv.se0 = 1'b0;
    u_bus.set_line(lv);
  endtask
  // Low speed K state: differential one held for the resume time
  task automatic t_resume();
    apb(1'b1, OFS_USB_FLAGS, 32'h30);
    lv.low_speed = 1'b1;
    u_bus.set_line(lv);
    cyc(230);
    rchk("resume_early", OFS_USB_FLAGS, 32'h20, 32'h0);
    cyc(25);
    rchk("resume_set", OFS_USB_FLAGS, 32'h20, 32'h20);
  endtask
  task automatic t_host();
    host_mode <= 1'b1;
    apb(1'b1, OFS_SOF_THR, 32'h12);
    apb(1'b1, OFS_USB_FLAGS, 32'hff);
    apb(1'b1, OFS_OTG_FLAGS, 32'hff);
    lv.id_pin = 1'b1;
    lv.diff = 1'b0;
    u_bus.set_line(lv);
    cyc(2);
    rchk("id_change", OFS_OTG_FLAGS, 32'h80, 32'h80);
    u_bus.set_frame(8'h12);
    cyc(1);
    u_bus.pulse(11'h400);
    cyc(2);
    rchk("frame_stall", OFS_USB_FLAGS, 32'h84, 32'h84);
    cyc(260);
    rchk("attach", OFS_USB_FLAGS, 32'h40, 32'h40);
    lv.se0 = 1'b1;
    u_bus.set_line(lv);
    cyc(260);
    rchk("detach", OFS_USB_FLAGS, 32'h01, 32'h01);
    host_mode <= 1'b0;
    cyc(1);
    rchk("dev_bit6", OFS_USB_FLAGS, 32'h40, 32'h0);
  endtask
  task automatic print_verdict();
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    host_mode = 1'b0;
    lv = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_token();
    t_error();
    t_supply();
    t_bus_reset();
    t_resume();
    t_host();
    print_verdict();
  end
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    print_verdict();
  end
endmodule // tb
